// file: logic/reset_control_pkg.sv
// Constants for the system reset control block
package reset_control_pkg;
    // Register map: printed offset 0xcf9 is not a multiple of four, so it is an index
    localparam logic [11:0] reset_control_index  = 12'hcf9;
    localparam logic [13:0] reset_control_addr   = {reset_control_index, 2'b00};
    localparam logic [7:0]  reset_control_reset  = 8'h00;
    localparam int          hard_select_pos      = 1;
    localparam int          trigger_pos          = 2;
    // Status register of own choice
    localparam logic [13:0] reset_status_addr    = 14'h0000;
    localparam int          status_hard_pos      = 0;
    localparam int          status_soft_pos      = 1;
    localparam int          status_pgood_pos     = 2;
    // Pulse length
    localparam int          pulse_ns_default     = 160;
    localparam int          clk_period_ps        = 5000;
    localparam int          pulse_cycles_default = (pulse_ns_default * 1000 + clk_period_ps - 1) / clk_period_ps;
    localparam logic [1:0]  resp_okay            = 2'b00;
    localparam logic [1:0]  resp_slverr          = 2'b10;
endpackage : reset_control_pkg

// file: logic/reset_pulse_timer.sv
// Counts out one reset pulse of a fixed length
`timescale 1ns/1ps
`default_nettype none
module reset_pulse_timer #(
    parameter int cycles = 32
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic start,
    output var  logic active
);
    localparam int cw = $clog2(cycles + 1);
    logic [cw-1:0] count;
    logic [cw-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start) begin
            next_count = cw'(cycles);
        end else if (count != '0) begin
            next_count = count - cw'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign active = (count != '0);
endmodule : reset_pulse_timer
`default_nettype wire

// file: logic/system_reset_control.sv
// Reset control register and hard/soft reset generation
// Summary of operation
// - Hard reset asserts processor, PCI and ISA resets and the core reset output.
// - Soft reset pulses only the processor warm-restart output.
// - A register write starts a reset only when trigger bit 2 is written from 0 to 1.
// - Bit 1 set selects hard reset, clear selects soft reset.
// - Power-good becoming asserted forces a hard reset regardless of register.
// - Trigger bit 2 always reads as zero.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module system_reset_control
    import reset_control_pkg::*;
#(
    parameter int pulse_cycles = pulse_cycles_default
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System pins
    input  wire logic        power_good_in,
    output var  logic        processor_hard_reset_out,
    output var  logic        pci_bus_reset_out_n,
    output var  logic        isa_bus_reset_drive,
    output var  logic        processor_init_out,
    output var  logic        core_reset_out
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic        aw_held, next_aw_held;
    logic        w_held, next_w_held;
    logic [13:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic        wr_fire;
    logic        ctrl_hit;

    // ------------------------------------------------------------
    // Register and reset state
    // ------------------------------------------------------------
    logic       hard_sel, next_hard_sel;
    logic       trig, next_trig;
    logic       pgood_d, next_pgood_d;
    logic       hard_start, soft_start;
    logic       hard_active, soft_active;
    logic [2:0] status, next_status;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        wr_fire  = aw_held && w_held && !bvalid;
        ctrl_hit = ({aw_addr[13:2], 2'b00} == reset_control_addr);
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (ctrl_hit || aw_addr[13:2] == reset_status_addr[13:2]) ? resp_okay : resp_slverr;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = resp_okay;
            next_rdata  = '0;
            if (s_axi_araddr[13:2] == reset_control_addr[13:2]) begin
                // Trigger bit never reads back
                next_rdata[hard_select_pos] = hard_sel;
            end else if (s_axi_araddr[13:2] == reset_status_addr[13:2]) begin
                next_rdata[2:0] = status;
            end else begin
                next_rresp = resp_slverr;
            end
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            bvalid  <= 1'b0;
            bresp   <= resp_okay;
            rvalid  <= 1'b0;
            rresp   <= resp_okay;
            rdata   <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            // Write readies registered from the next hold state, read ready from the next read valid
            s_axi_awready <= !next_aw_held;
            s_axi_wready  <= !next_w_held;
            s_axi_arready <= !next_rvalid;
        end
    end

    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;

    // ------------------------------------------------------------
    // Reset control register and triggers
    // ------------------------------------------------------------
    always_comb begin
        next_hard_sel = hard_sel;
        next_trig     = trig;
        next_pgood_d  = power_good_in;
        next_status   = status;
        hard_start    = 1'b0;
        soft_start    = 1'b0;
        if (wr_fire && ctrl_hit && w_strb[0]) begin
            next_hard_sel = w_data[hard_select_pos];
            next_trig     = w_data[trigger_pos];
            if (w_data[trigger_pos] && !trig) begin
                hard_start = w_data[hard_select_pos];
                soft_start = !w_data[hard_select_pos];
            end
        end
        if (power_good_in && !pgood_d) begin
            hard_start = 1'b1;
        end
        if (wr_fire && aw_addr[13:2] == reset_status_addr[13:2] && w_strb[0]) begin
            next_status = status & ~w_data[2:0];
        end
        // Set wins over clear
        if (hard_start) begin
            next_status[status_hard_pos] = 1'b1;
        end
        if (soft_start) begin
            next_status[status_soft_pos] = 1'b1;
        end
        if (power_good_in && !pgood_d) begin
            next_status[status_pgood_pos] = 1'b1;
        end
        if (hard_active) begin
            // Register returns to default with the core
            next_hard_sel = 1'b0;
            next_trig     = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hard_sel <= reset_control_reset[hard_select_pos];
            trig     <= reset_control_reset[trigger_pos];
            pgood_d  <= 1'b0;
            status   <= '0;
        end else begin
            hard_sel <= next_hard_sel;
            trig     <= next_trig;
            pgood_d  <= next_pgood_d;
            status   <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Pulse timers and outputs
    // ------------------------------------------------------------
    reset_pulse_timer #(.cycles(pulse_cycles)) hard_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (hard_start),
        .active  (hard_active)
    );

    reset_pulse_timer #(.cycles(pulse_cycles)) soft_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (soft_start && !hard_active && !hard_start),
        .active  (soft_active)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            processor_hard_reset_out <= 1'b0;
            pci_bus_reset_out_n      <= 1'b1;
            isa_bus_reset_drive      <= 1'b0;
            core_reset_out           <= 1'b0;
            processor_init_out       <= 1'b0;
        end else begin
            processor_hard_reset_out <= hard_active;
            pci_bus_reset_out_n      <= !hard_active;
            isa_bus_reset_drive      <= hard_active;
            core_reset_out           <= hard_active;
            processor_init_out       <= soft_active;
        end
    end
endmodule : system_reset_control
`default_nettype wire

// file: verif/reset_sink.sv
// Host side model counting the reset pulses it receives
`timescale 1ns/1ps
`default_nettype none
module reset_sink (
    // Clock and reset pins
    input wire logic aclk,
    input wire logic processor_hard_reset_out,
    input wire logic pci_bus_reset_out_n,
    input wire logic isa_bus_reset_drive,
    input wire logic processor_init_out,
    // Pulse counts
    output var int   hard_cnt = 0,
    output var int   soft_cnt = 0
);
    logic hq = 0;
    logic sq = 0;
    always @(posedge aclk) begin
        if (processor_hard_reset_out && !hq && !pci_bus_reset_out_n && isa_bus_reset_drive) hard_cnt++;
        if (processor_init_out && !sq) soft_cnt++;
        hq <= processor_hard_reset_out;
        sq <= processor_init_out;
    end
endmodule : reset_sink
`default_nettype wire

// file: verif/system_reset_control_properties.sv
// Assertions on the reset control block ports
`timescale 1ns/1ps
`default_nettype none
module system_reset_control_properties
    import reset_control_pkg::*;
#(
    parameter int pulse_cycles = 32
) (
    // Clock, reset and bus
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [13:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_bvalid,
    // System pins
    input wire logic        power_good_in,
    input wire logic        processor_hard_reset_out,
    input wire logic        pci_bus_reset_out_n,
    input wire logic        isa_bus_reset_drive,
    input wire logic        processor_init_out,
    input wire logic        core_reset_out
);
    logic ctl_rd;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Remember which register a read targets
    always_ff @(posedge aclk)
        if (s_axi_arvalid && s_axi_arready) ctl_rd <= (s_axi_araddr == reset_control_addr);
    hard_group_a: assert property (
        isa_bus_reset_drive == processor_hard_reset_out && core_reset_out == processor_hard_reset_out
        && pci_bus_reset_out_n == !processor_hard_reset_out) else $error("hard outputs disagree");
    soft_alone_a: assert property (
        $rose(processor_init_out) |-> pci_bus_reset_out_n && !core_reset_out) else $error("soft touched hard");
    init_cause_a: assert property (
        $rose(processor_init_out) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        else $error("init without write");
    hard_cause_a: assert property (
        $rose(processor_hard_reset_out) |-> $past(s_axi_bvalid) || $past(power_good_in, 2))
        else $error("hard without cause");
    pgood_hard_a: assert property (
        $rose(power_good_in) |-> ##[1:8] processor_hard_reset_out) else $error("power good ignored");
    trig_read_a: assert property (
        s_axi_rvalid && ctl_rd |-> s_axi_rdata[2] == 1'b0) else $error("trigger read as one");
    pulse_len_a: assert property (
        $fell(processor_init_out) && $past(aresetn) |-> $past(processor_init_out, pulse_cycles)
        && !$past(processor_init_out, pulse_cycles + 1)) else $error("init pulse length");
endmodule : system_reset_control_properties
bind system_reset_control system_reset_control_properties #(.pulse_cycles(pulse_cycles)) props (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_bvalid, .power_good_in, .processor_hard_reset_out, .pci_bus_reset_out_n,
    .isa_bus_reset_drive, .processor_init_out, .core_reset_out);
`default_nettype wire

// file: verif/test_system_reset_control.sv
// Self-checking bench for the system reset control block
`timescale 1ns/1ps
`default_nettype none
module test_system_reset_control
    import reset_control_pkg::*;
;
    localparam int pc = 4;
    logic        aclk = 0, aresetn = 0, power_good_in = 0;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        processor_hard_reset_out, pci_bus_reset_out_n, isa_bus_reset_drive;
    logic        processor_init_out, core_reset_out;
    int          hard_cnt, soft_cnt, bad_count = 0, compares = 0;
    int          core_cnt = 0;
    logic        core_q = 0;
    localparam logic [7:0] all_status = 8'((1 << status_hard_pos) | (1 << status_soft_pos) | (1 << status_pgood_pos));
    logic [1:0]  bq[$];
    logic [33:0] rq[$];

    system_reset_control #(.pulse_cycles(pc)) uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .power_good_in, .processor_hard_reset_out,
        .pci_bus_reset_out_n, .isa_bus_reset_drive, .processor_init_out, .core_reset_out);
    reset_sink host (.aclk, .processor_hard_reset_out, .pci_bus_reset_out_n, .isa_bus_reset_drive,
        .processor_init_out, .hard_cnt, .soft_cnt);

    initial forever #2.5 aclk = ~aclk;

    task automatic conclude();
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
        bq.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask : wr

    task automatic rd(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
        rq.push_back({24'h0, d, r});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
    endtask : rd

    task automatic pulses(input int h, input int s);
        repeat (pc + 8) @(posedge aclk);
        chk(hard_cnt, h, "hard count");
        chk(soft_cnt, s, "soft count");
        chk(core_cnt, h, "core count");
    endtask : pulses

    // Results are matched against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid) chk(s_axi_bresp, bq.pop_front(), "bresp");
        if (s_axi_rvalid) chk({s_axi_rdata, s_axi_rresp}, rq.pop_front(), "read");
        if (core_reset_out && !core_q) core_cnt++;
        core_q <= core_reset_out;
    end

    initial begin
        repeat (3000) @(posedge aclk);
        bad_count++;
        conclude();
    end

    initial begin
        logic [13:0] junk;
        void'($urandom(32'h12cb));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(reset_control_addr, 8'h00, resp_okay);
        wr(reset_control_addr, 8'h04, resp_okay);
        pulses(0, 1);
        rd(reset_control_addr, 8'h00, resp_okay);
        wr(reset_control_addr, 8'h04, resp_okay);
        pulses(0, 1);
        wr(reset_control_addr, 8'h02, resp_okay);
        rd(reset_control_addr, 8'h02, resp_okay);
        wr(reset_control_addr, 8'h06, resp_okay);
        pulses(1, 1);
        rd(reset_control_addr, 8'h00, resp_okay);
        wr(reset_control_addr, 8'h04, resp_okay);
        pulses(1, 2);
        wr(reset_control_addr, 8'h00, resp_okay);
        junk = {12'($urandom_range(3319, 1)), 2'b00};
        wr(junk, 8'h06, resp_slverr);
        rd(junk, 8'h00, resp_slverr);
        pulses(1, 2);
        power_good_in <= 1'b1;
        pulses(2, 2);
        rd(reset_status_addr, all_status, resp_okay);
        wr(reset_status_addr, all_status, resp_okay);
        rd(reset_status_addr, 8'h00, resp_okay);
        conclude();
    end
endmodule : test_system_reset_control
`default_nettype wire
